// file: src/led_mux_pkg.sv
// constants, encodings and types shared by the led output mapper
package led_mux_pkg;

   // ==========================================================
   // register byte offsets
   localparam int ADDR_W = 6;
   localparam logic [ADDR_W-1:0] OFF_CTRL = 6'h00;
   localparam logic [ADDR_W-1:0] OFF_DECODE = 6'h04;
   localparam logic [ADDR_W-1:0] OFF_DIGIT0 = 6'h08;
   localparam logic [ADDR_W-1:0] OFF_DIGIT3 = 6'h14;
   localparam logic [ADDR_W-1:0] OFF_EXTRA = 6'h18;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 6'h1C;

   // ==========================================================
   // field positions
   localparam int CTRL_NINTH_LSB = 0;
   localparam int CTRL_LOGIC_BIT = 2;
   localparam int CTRL_KEY1_BIT = 3;
   localparam int CTRL_KEY2_BIT = 4;
   localparam int STAT_KEY_LSB = 0;
   localparam int STAT_INPUT_LSB = 8;
   localparam int STAT_EVENT_BIT = 10;
   localparam int STAT_DIGIT_LSB = 12;

   // ==========================================================
   // reset values
   localparam logic [4:0] CTRL_RST = 5'h00;
   localparam logic [3:0] DECODE_RST = 4'h0;
   localparam logic [7:0] DIGIT_RST = 8'h00;
   localparam logic [7:0] EXTRA_RST = 8'h00;

   // ==========================================================
   // ninth output functions
   localparam logic [1:0] NINTH_SEG = 2'h0;
   localparam logic [1:0] NINTH_IRQ = 2'h1;
   localparam logic [1:0] NINTH_LOGIC = 2'h2;

   // ==========================================================
   // bus answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ==========================================================
   // timing
   localparam int CLK_PERIOD_NS = 20;
   localparam int SPIKE_NS = 50;
   localparam int FILT_CYCLES = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FILT_W = 2;
   localparam logic [FILT_W-1:0] FILT_LAST = FILT_W'(FILT_CYCLES - 1);
   localparam int TMR_W = 10;
   localparam int SLOT_CYCLES = 1000;
   localparam int BLANK_CYCLES = 4;
   localparam logic [TMR_W-1:0] SLOT_LAST = TMR_W'(SLOT_CYCLES - 1);
   localparam logic [TMR_W-1:0] BLANK_LAST = TMR_W'(BLANK_CYCLES - 1);
   localparam int DEB_W = 2;
   localparam int DEB_SCANS = 3;
   localparam logic [DEB_W-1:0] DEB_LAST = DEB_W'(DEB_SCANS - 1);

   // ==========================================================
   // types
   typedef enum logic {ST_BLANK, ST_LIT} scan_state_t;
   typedef enum logic [2:0] {SEL_CTRL, SEL_DECODE, SEL_DIGIT, SEL_EXTRA, SEL_STATUS,
                             SEL_NONE} reg_sel_t;

endpackage

// file: src/filt_if.sv
// carrier between the mapper and its serial line spike filter
`timescale 1ns/1ns
`default_nettype none
interface filt_if;
   // raw and filtered levels, index 0 clock, index 1 data
   logic [1:0] raw;
   wire logic [1:0] clean;
   modport filt (input raw, output clean);
   modport user (output raw, input clean);
endinterface
`default_nettype wire

// file: src/spike_filter.sv
// spike filter for the serial clock and data lines
`timescale 1ns/1ns
`default_nettype none
module spike_filter
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // filtered lines
   filt_if.filt lines
);
   import led_mux_pkg::*;

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // ==========================================================
   // one filter per line
   genvar i;
   generate
      for (i = 0; i < 2; i++)
      begin : g_line
         logic [FILT_W-1:0] cnt;
         logic level;
         wire differs = lines.raw[i] != level;
         // spike rejection: follow only a level held FILT_CYCLES samples
         always_ff @(posedge aclk)
         begin
            if (!aresetn)
            begin
               level <= 1'b1;
               cnt <= '0;
            end
            else if (!differs)
               cnt <= '0;
            else if (cnt == FILT_LAST)
            begin
               level <= lines.raw[i];
               cnt <= '0;
            end
            else
               cnt <= cnt + 1'b1;
         end
         assign lines.clean[i] = level;
         chk_spike_reject: assert property (
            $changed(level) |-> ($past(lines.raw[i], 1) == level) &&
               ($past(lines.raw[i], 2) == level) && ($past(lines.raw[i], 3) == level))
            else $error("filtered line moved after a short pulse");
      end
   endgenerate

endmodule
`default_nettype wire

// file: src/led_mux_output_mapper.sv
// scan sequencer, pin mapper, keyscan and register slave of the led driver
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// - shared pin sinks own digit, sources others
// - undriven digit or segment pins released
// - pins 4 to 8 carry e,d,c,b,a
// - g,f swap shared pin pair by digit
// - eight extra bits on spare pins
// - extra bits 0-3 discrete only when shared
// - per digit raw segments or hex font
// - ninth pin segment, interrupt or logic
// - input ports logic or keyscan, pulled up
// - serial lines spike filtered before use
// - keyscan debounces four keys per port
module led_mux_output_mapper
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address and data
   input wire logic [led_mux_pkg::ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   // axi4-lite write response
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // axi4-lite read
   input wire logic [led_mux_pkg::ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // shared digit and segment pins
   output logic [3:0] shared_out_val,
   output logic [3:0] shared_out_drive_n,
   // dedicated segment pins 4 to 8
   output logic [4:0] seg_out_val,
   output logic [4:0] seg_out_drive_n,
   // ninth segment, interrupt or logic pin
   output logic ninth_out_multi,
   output logic ninth_out_multi_drive_n,
   // input ports
   input wire logic input_port_one,
   input wire logic input_port_two,
   output logic [1:0] input_pullup_en,
   // serial lines
   input wire logic scl_raw,
   input wire logic sda_raw,
   output logic scl_clean,
   output logic sda_clean
);
   import led_mux_pkg::*;

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // ==========================================================
   // helper functions
   // register select from a byte address
   function automatic reg_sel_t decode_reg(input logic [ADDR_W-1:0] addr);
      logic [ADDR_W-1:0] a;
      a = {addr[ADDR_W-1:2], 2'b00};
      if (a == OFF_CTRL)
         return SEL_CTRL;
      else if (a == OFF_DECODE)
         return SEL_DECODE;
      else if (a >= OFF_DIGIT0 && a <= OFF_DIGIT3)
         return SEL_DIGIT;
      else if (a == OFF_EXTRA)
         return SEL_EXTRA;
      else if (a == OFF_STATUS)
         return SEL_STATUS;
      else
         return SEL_NONE;
   endfunction

   // hex font, bits a b c d e f g from msb down
   function automatic logic [6:0] hex_font(input logic [3:0] v);
      case (v)
         4'h0: return 7'h7E;
         4'h1: return 7'h30;
         4'h2: return 7'h6D;
         4'h3: return 7'h79;
         4'h4: return 7'h33;
         4'h5: return 7'h5B;
         4'h6: return 7'h5F;
         4'h7: return 7'h70;
         4'h8: return 7'h7F;
         4'h9: return 7'h7B;
         4'hA: return 7'h77;
         4'hB: return 7'h1F;
         4'hC: return 7'h4E;
         4'hD: return 7'h3D;
         4'hE: return 7'h4F;
         default: return 7'h47;
      endcase
   endfunction

   // ==========================================================
   // registers and bus slave
   logic [4:0] ctrl;
   logic [3:0] decode_mask;
   logic [7:0] digit_data [4];
   logic [7:0] extra;
   logic key_event;
   logic [1:0] input_level;
   logic aw_held;
   logic w_held;
   logic [ADDR_W-1:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic [31:0] rd_word;
   wire [7:0] key_state;
   wire [7:0] key_flip;
   scan_state_t state;
   logic [TMR_W-1:0] tmr;
   logic [1:0] digit;

   // handshake and decode
   assign awready = !aw_held && !bvalid;
   assign wready = !w_held && !bvalid;
   assign arready = !rvalid;
   wire wr_fire = aw_held && w_held && !bvalid;
   wire reg_sel_t wr_sel = decode_reg(aw_addr_q);
   wire reg_sel_t rd_sel = decode_reg(araddr);
   wire [1:0] wr_digit = aw_addr_q[3:2] + 2'h2;
   wire [1:0] rd_digit = araddr[3:2] + 2'h2;
   wire event_clr = wr_fire && wr_sel == SEL_STATUS && w_strb_q[1] && w_data_q[STAT_EVENT_BIT];
   wire next_event = (key_event && !event_clr) || (|key_flip);

   // write channels are caught in either order, then applied together
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr_q <= '0;
         w_data_q <= '0;
         w_strb_q <= '0;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
      end
      else
      begin
         if (awvalid && awready)
         begin
            aw_held <= 1'b1;
            aw_addr_q <= awaddr;
         end
         if (wvalid && wready)
         begin
            w_held <= 1'b1;
            w_data_q <= wdata;
            w_strb_q <= wstrb;
         end
         if (wr_fire)
         begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            bvalid <= 1'b1;
            bresp <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
         end
         else if (bvalid && bready)
            bvalid <= 1'b0;
      end
   end

   // register stores; the key event is set over a clear in the same cycle
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl <= CTRL_RST;
         decode_mask <= DECODE_RST;
         digit_data <= '{default: DIGIT_RST};
         extra <= EXTRA_RST;
         key_event <= 1'b0;
         input_level <= 2'b11;
      end
      else
      begin
         key_event <= next_event;
         input_level <= {input_port_two, input_port_one};
         if (wr_fire && w_strb_q[0])
         begin
            if (wr_sel == SEL_CTRL)
               ctrl <= w_data_q[4:0];
            else if (wr_sel == SEL_DECODE)
               decode_mask <= w_data_q[3:0];
            else if (wr_sel == SEL_DIGIT)
               digit_data[wr_digit] <= w_data_q[7:0];
            else if (wr_sel == SEL_EXTRA)
               extra <= w_data_q[7:0];
         end
      end
   end

   // read word selection
   always_comb
   begin
      rd_word = 32'h0000_0000;
      if (rd_sel == SEL_CTRL)
         rd_word[4:0] = ctrl;
      else if (rd_sel == SEL_DECODE)
         rd_word[3:0] = decode_mask;
      else if (rd_sel == SEL_DIGIT)
         rd_word[7:0] = digit_data[rd_digit];
      else if (rd_sel == SEL_EXTRA)
         rd_word[7:0] = extra;
      else if (rd_sel == SEL_STATUS)
      begin
         rd_word[STAT_KEY_LSB +: 8] = key_state;
         rd_word[STAT_INPUT_LSB +: 2] = input_level;
         rd_word[STAT_EVENT_BIT] = key_event;
         rd_word[STAT_DIGIT_LSB +: 2] = digit;
      end
   end

   // read answer one cycle after the address is taken
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid <= 1'b0;
         rdata <= '0;
         rresp <= RESP_OKAY;
      end
      else if (arvalid && arready)
      begin
         rvalid <= 1'b1;
         rdata <= rd_word;
         rresp <= (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end
      else if (rvalid && rready)
         rvalid <= 1'b0;
   end

   chk_bvalid_hold: assert property (bvalid && !bready |=> bvalid)
      else $error("write answer dropped before it was taken");

   // ==========================================================
   // scan sequencer
   wire lit = state == ST_LIT;
   wire scan_sample = lit && tmr == SLOT_LAST;

   // blank gap then one lit slot per digit, in order
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state <= ST_BLANK;
         tmr <= '0;
         digit <= 2'h0;
      end
      else
      begin
         case (state)
            ST_BLANK:
               if (tmr == BLANK_LAST)
               begin
                  state <= ST_LIT;
                  tmr <= '0;
               end
               else
                  tmr <= tmr + 1'b1;
            default:
               if (tmr == SLOT_LAST)
               begin
                  state <= ST_BLANK;
                  tmr <= '0;
                  digit <= digit + 2'h1;
               end
               else
                  tmr <= tmr + 1'b1;
         endcase
      end
   end

   sequence s_blank_gap;
      (!lit) [*4];
   endsequence
   sequence s_relit;
      lit;
   endsequence
   chk_blank_span: assert property ($fell(lit) |-> s_blank_gap ##1 s_relit)
      else $error("blank gap between slots has the wrong length");
   chk_slot_min: assert property ($rose(lit) |-> lit [*8])
      else $error("lit slot ended too early");

   // ==========================================================
   // segment source and pin mapping
   wire [1:0] ninth_mode = ctrl[CTRL_NINTH_LSB +: 2];
   wire [7:0] cur_data = digit_data[digit];
   wire [6:0] font_val = hex_font(cur_data[3:0]);
   // font or direct bits per digit
   wire [6:0] segs = decode_mask[digit] ? font_val : cur_data[6:0];
   wire lo_pair = !digit[1];
   wire [9:0] lit_vec;
   wire [9:0] cath_vec;
   logic [9:0] pout;
   logic [9:0] pdrv_n;
   wire [9:0] next_out;
   wire [9:0] next_drive_n;

   // only the scanned digit's own pin sinks
   assign cath_vec = lit ? {6'h00, 4'h1 << digit} : 10'h000;
   // fixed segment pins e d c b a
   assign lit_vec[8:4] = lit ? segs[6:2] : 5'h00;
   // g and f move to the other shared pair; discrete bits fill the spare pin
   assign lit_vec[3] = lit && (lo_pair ? segs[1] : (digit == 2'h2 && extra[2]));
   assign lit_vec[2] = lit && (lo_pair ? segs[0] : (digit == 2'h3 && extra[3]));
   assign lit_vec[1] = lit && (lo_pair ? (digit == 2'h0 && extra[0]) : segs[1]);
   assign lit_vec[0] = lit && (lo_pair ? (digit == 2'h1 && extra[1]) : segs[0]);
   // bits 4 to 7 on the ninth pin as decimal points
   assign lit_vec[9] = lit && ninth_mode == NINTH_SEG && extra[{1'b1, digit}];

   // a pin neither sinking nor lit is released
   genvar p;
   generate
      for (p = 0; p < 9; p++)
      begin : g_pin
         assign next_drive_n[p] = !(cath_vec[p] || lit_vec[p]);
         assign next_out[p] = lit_vec[p] && !cath_vec[p];
      end
   endgenerate

   // segment mode sources, other modes only pull low or release
   assign next_drive_n[9] = (ninth_mode == NINTH_SEG) ? !lit_vec[9] :
                            (ninth_mode == NINTH_IRQ) ? !key_event :
                            (ninth_mode == NINTH_LOGIC) ? ctrl[CTRL_LOGIC_BIT] : 1'b1;
   assign next_out[9] = (ninth_mode == NINTH_SEG) && lit_vec[9];

   // pin levels and enables from flip-flops
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pout <= 10'h000;
         pdrv_n <= 10'h3FF;
      end
      else
      begin
         pout <= next_out;
         pdrv_n <= next_drive_n;
      end
   end

   assign shared_out_val = pout[3:0];
   assign shared_out_drive_n = pdrv_n[3:0];
   assign seg_out_val = pout[8:4];
   assign seg_out_drive_n = pdrv_n[8:4];
   assign ninth_out_multi = pout[9];
   assign ninth_out_multi_drive_n = pdrv_n[9];

   chk_cathode_slot: assert property (lit |=> !pdrv_n[$past(digit)] && !pout[$past(digit)])
      else $error("scanned digit pin is not sinking");
   chk_one_cathode: assert property ($onehot0(~pdrv_n[3:0] & ~pout[3:0]))
      else $error("more than one cathode sinking");
   chk_blank_release: assert property (!lit |=> pdrv_n[8:0] == 9'h1FF)
      else $error("digit or segment pin driven while blank");
   chk_fixed_segs: assert property (lit |=> pdrv_n[8:4] == ~$past(segs[6:2]))
      else $error("fixed segment pins do not follow e to a");
   chk_gf_routing: assert property (lit && digit[1] |=> pdrv_n[1:0] == ~$past(segs[1:0]))
      else $error("g and f not on shared pins 0 and 1");
   chk_spare_bit: assert property (lit && digit == 2'h3 |=> pdrv_n[2] == !$past(extra[3]))
      else $error("discrete bit 3 missing on spare pin");
   chk_font_pins: assert property (lit && decode_mask[digit] |=> pout[8:4] == $past(font_val[6:2]))
      else $error("decoded digit does not show its font");
   chk_ninth_od: assert property (ninth_mode != NINTH_SEG |=> !(pout[9] && !pdrv_n[9]))
      else $error("ninth pin sourced outside segment mode");
   chk_irq_pull: assert property (ninth_mode == NINTH_IRQ && key_event |=> !pdrv_n[9])
      else $error("interrupt pin not pulled low");

   // ==========================================================
   // input ports and keyscan
   wire [1:0] port_in = {input_port_two, input_port_one};
   wire [1:0] keyscan_en = {ctrl[CTRL_KEY2_BIT], ctrl[CTRL_KEY1_BIT]};

   // pull-ups stay on so an open port reads high
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         input_pullup_en <= 2'b11;
      else
         input_pullup_en <= 2'b11;
   end

   // four keys per port, one per digit slot, debounced over scans
   genvar k;
   generate
      for (k = 0; k < 8; k++)
      begin : g_key
         logic kst;
         logic [DEB_W-1:0] kcnt;
         wire sample_now = scan_sample && digit == 2'(k % 4);
         wire pressed = !port_in[k / 4];
         always_ff @(posedge aclk)
         begin
            if (!aresetn || !keyscan_en[k / 4])
            begin
               kst <= 1'b0;
               kcnt <= '0;
            end
            else if (sample_now)
            begin
               if (pressed == kst)
                  kcnt <= '0;
               else if (kcnt == DEB_LAST)
               begin
                  kst <= pressed;
                  kcnt <= '0;
               end
               else
                  kcnt <= kcnt + 1'b1;
            end
         end
         assign key_state[k] = kst;
         assign key_flip[k] = sample_now && keyscan_en[k / 4] && pressed != kst &&
                              kcnt == DEB_LAST;
      end
   endgenerate

   chk_key_event: assert property (|key_flip |=> key_event)
      else $error("debounced key change did not raise the event");
   chk_pullup_on: assert property (input_pullup_en == 2'b11)
      else $error("input pull-up switched off");

   // ==========================================================
   // serial line filters
   filt_if lines ();
   assign lines.raw = {sda_raw, scl_raw};
   // spike filters ahead of the protocol logic
   spike_filter u_filter
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .lines(lines.filt)
   );
   assign scl_clean = lines.clean[0];
   assign sda_clean = lines.clean[1];

endmodule
`default_nettype wire

// file: verif/led_panel_model.sv
// display and key matrix model on the far side of the pin mapper
`timescale 1ns/1ns
`default_nettype none
module led_panel_model
(
   // clock
   input wire logic aclk,
   // pins from the mapper
   input wire logic [3:0] shared_out_val,
   input wire logic [3:0] shared_out_drive_n,
   input wire logic [1:0] input_pullup_en,
   // key matrix, key k on port k/4 and slot k%4
   input wire logic [7:0] keys,
   // input port levels
   output logic input_port_one,
   output logic input_port_two
);
   logic [3:0] sink;
   logic [1:0] low;
   logic [1:0] flip = 2'h0;
   assign sink = ~shared_out_drive_n & ~shared_out_val;
   assign low = {|(keys[7:4] & sink), |(keys[3:0] & sink)};
   assign input_port_one = low[0] ? 1'b0 : (input_pullup_en[0] ? 1'b1 : flip[0]);
   assign input_port_two = low[1] ? 1'b0 : (input_pullup_en[1] ? 1'b1 : flip[1]);
   // a port left floating wanders every cycle
   always @(posedge aclk)
      flip <= ~flip;
endmodule
`default_nettype wire

// file: verif/led_mux_output_mapper_tb.sv
// self-checking bench of the led output mapper
`timescale 1ns/1ns
`default_nettype none
module led_mux_output_mapper_tb;
   import led_mux_pkg::*;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, scl_raw, sda_raw;
   logic awready, wready, bvalid, arready, rvalid, ninth_out_multi, ninth_out_multi_drive_n;
   logic scl_clean, sda_clean, input_port_one, input_port_two;
   logic [5:0] awaddr, araddr;
   logic [31:0] wdata, rdata, st;
   logic [3:0] wstrb, shared_out_val, shared_out_drive_n;
   logic [1:0] bresp, rresp, input_pullup_en, r;
   logic [4:0] seg_out_val, seg_out_drive_n;
   logic [7:0] keys, x;
   logic [6:0] s [4];
   logic [7:0] dat [4];
   logic [3:0] dec;
   int n_errors = 0, checks = 0, cycles = 0, seed = 8658;
   logic [6:0] font [16] = '{7'h7E, 7'h30, 7'h6D, 7'h79, 7'h33, 7'h5B, 7'h5F, 7'h70,
                             7'h7F, 7'h7B, 7'h77, 7'h1F, 7'h4E, 7'h3D, 7'h4F, 7'h47};

   // ==========================================================
   // design and display
   led_mux_output_mapper uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .shared_out_val(shared_out_val), .shared_out_drive_n(shared_out_drive_n),
      .seg_out_val(seg_out_val), .seg_out_drive_n(seg_out_drive_n),
      .ninth_out_multi(ninth_out_multi), .ninth_out_multi_drive_n(ninth_out_multi_drive_n),
      .input_port_one(input_port_one), .input_port_two(input_port_two),
      .input_pullup_en(input_pullup_en), .scl_raw(scl_raw), .sda_raw(sda_raw),
      .scl_clean(scl_clean), .sda_clean(sda_clean));
   led_panel_model panel (.aclk(aclk), .shared_out_val(shared_out_val),
      .shared_out_drive_n(shared_out_drive_n), .input_pullup_en(input_pullup_en),
      .keys(keys), .input_port_one(input_port_one), .input_port_two(input_port_two));

   // ==========================================================
   // clock, timeout and cathode monitor
   initial
   begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end
   always @(posedge aclk)
   begin
      cycles++;
      if (cycles == 100000)
      begin
         n_errors++;
         give_verdict();
      end
      if (aresetn === 1'b1)
         chk("cathodes", {31'h0, $countones(~shared_out_drive_n & ~shared_out_val) > 1}, 0);
   end

   // ==========================================================
   // helpers
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic give_verdict();
      if (n_errors == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] b);
      logic ad, wd;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= b;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      ad = 1'b0;
      wd = 1'b0;
      while (!(ad && wd))
      begin
         @(posedge aclk);
         if (!ad && awready === 1'b1)
         begin
            ad = 1'b1;
            awvalid <= 1'b0;
         end
         if (!wd && wready === 1'b1)
         begin
            wd = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [5:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      st = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
   function automatic logic [1:0] lit(input logic b);
      return b ? 2'h2 : 2'h0;
   endfunction
   // pin codes: 0 released, 1 sinking, 2 sourcing
   function automatic logic [19:0] pins_now();
      logic [9:0] dn;
      logic [9:0] v;
      logic [19:0] p;
      dn = {ninth_out_multi_drive_n, seg_out_drive_n, shared_out_drive_n};
      v = {ninth_out_multi, seg_out_val, shared_out_val};
      for (int i = 0; i < 10; i++)
         p[2*i+:2] = dn[i] ? 2'h0 : (v[i] ? 2'h2 : 2'h1);
      return p;
   endfunction
   function automatic logic [19:0] pins_exp(input int d, input logic [6:0] g, input logic [7:0] e);
      logic [19:0] p;
      int gp;
      p = '0;
      gp = (d < 2) ? 2 : 0;
      for (int i = 0; i < 5; i++)
         p[2*(4+i)+:2] = lit(g[2+i]);
      p[2*gp+:2] = lit(g[0]);
      p[2*gp+2+:2] = lit(g[1]);
      p[2*(d^1)+:2] = lit(e[d]);
      p[18+:2] = lit(e[4+d]);
      p[2*d+:2] = 2'h1;
      return p;
   endfunction

   // ==========================================================
   // main sequence
   initial
   begin
      {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, wstrb} = '0;
      {scl_raw, sda_raw, aresetn, keys} = {2'h3, 1'b0, 8'h00};
      repeat (16) @(posedge aclk);
      chk("pins_in_reset", pins_now(), 0);
      chk("pullups", input_pullup_en, 2'h3);
      aresetn <= 1'b1;
      foreach (dat[i])
      begin
         rd(6'(4*i));
         chk("reset_word", st, 0);
         chk("rd_resp", r, RESP_OKAY);
      end
      rd(6'h20);
      chk("unmapped_read", r, RESP_SLVERR);
      wr(6'h20, 32'h1, 4'hF);
      chk("unmapped_write", r, RESP_SLVERR);
      // 40 ns spike dropped, long low passes
      sda_raw <= 1'b0;
      repeat (2) @(posedge aclk);
      sda_raw <= 1'b1;
      @(posedge aclk);
      chk("sda_spike", sda_clean, 1);
      scl_raw <= 1'b0;
      repeat (4) @(posedge aclk);
      chk("scl_low", scl_clean, 0);
      scl_raw <= 1'b1;
      repeat (4) @(posedge aclk);
      chk("scl_high", scl_clean, 1);
      // four all-font passes cover every glyph, then mixed passes
      for (int p = 0; p < 6; p++)
      begin
         dec = (p < 4) ? 4'hF : 4'($random(seed));
         x = 8'($random(seed));
         wr(OFF_DECODE, {28'h0, dec}, 4'h1);
         chk("wr_resp", r, RESP_OKAY);
         wr(OFF_EXTRA, {24'h0, x}, 4'h1);
         for (int d = 0; d < 4; d++)
         begin
            dat[d] = (p < 4) ? {4'($random(seed)), 4'(4*p+d)} : 8'($random(seed));
            s[d] = dec[d] ? font[dat[d][3:0]] : dat[d][6:0];
            wr(6'(OFF_DIGIT0 + 4*d), {24'h0, dat[d]}, 4'h1);
         end
         for (int d = 0; d < 4; d++)
         begin
            do rd(OFF_STATUS); while (st[13:12] == 2'(d));
            do rd(OFF_STATUS); while (st[13:12] != 2'(d));
            repeat (20) @(posedge aclk);
            chk("pins", pins_now(), pins_exp(d, s[d], x));
         end
      end
      // keys on port one slot 0 and port two slot 2 raise the interrupt pin
      // the status read falls early in slot 3, so both port levels read high
      keys <= 8'h41;
      wr(OFF_CTRL, 32'h18 | NINTH_IRQ, 4'h1);
      repeat (20100) @(posedge aclk);
      rd(OFF_STATUS);
      chk("keys", st[10:0], 11'h741);
      chk("irq_pin", {ninth_out_multi_drive_n, ninth_out_multi}, 2'h0);
      wr(OFF_STATUS, 32'h400, 4'h2);
      repeat (2) @(posedge aclk);
      chk("irq_release", ninth_out_multi_drive_n, 1);
      keys <= 8'h00;
      wr(OFF_CTRL, NINTH_LOGIC, 4'h1);
      repeat (2) @(posedge aclk);
      chk("logic_low", {ninth_out_multi_drive_n, ninth_out_multi}, 2'h0);
      wr(OFF_CTRL, 32'h4 | NINTH_LOGIC, 4'h1);
      repeat (2) @(posedge aclk);
      chk("logic_high", ninth_out_multi_drive_n, 1);
      rd(OFF_STATUS);
      chk("keys_off", st[10:0], 11'h300);
      // spare ninth pin function leaves the pin released
      wr(OFF_CTRL, 32'h3, 4'h1);
      repeat (2) @(posedge aclk);
      chk("ninth_off", {ninth_out_multi_drive_n, ninth_out_multi}, 2'h2);
      give_verdict();
   end
endmodule
`default_nettype wire
